// >>> pkg/uam_pkg.sv
// shared constants and carrier types of the memory-mapped register decode
package uam_pkg;
  localparam int CHANNELS = 2;
  localparam int BLOCK_BYTES = 512;
  localparam int FIFO_DEPTH = 128;
  localparam logic [31:0] CH_STRIDE = 32'h0000_0200;
  // byte offsets inside a channel block
  localparam logic [8:0] OFS_HOLD = 9'h000;
  localparam logic [8:0] OFS_INT_EN = 9'h001;
  localparam logic [8:0] OFS_INT_FIFO = 9'h002;
  localparam logic [8:0] OFS_LINE_CTRL = 9'h004;
  localparam logic [8:0] OFS_LINE_STAT = 9'h005;
  localparam logic [8:0] OFS_MODEM_STAT = 9'h006;
  localparam logic [8:0] OFS_SPECIAL = 9'h007;
  localparam logic [8:0] OFS_DIV_LOW = 9'h008;
  localparam logic [8:0] OFS_DIV_HIGH = 9'h009;
  localparam logic [8:0] OFS_ENH_FUNC = 9'h00a;
  localparam logic [8:0] OFS_CHAR_FIRST = 9'h00b;
  localparam logic [8:0] OFS_CHAR_LAST = 9'h00e;
  localparam logic [8:0] OFS_ADD_CTRL = 9'h00f;
  localparam logic [8:0] OFS_TX_TRIG = 9'h010;
  localparam logic [8:0] OFS_RX_TRIG = 9'h011;
  localparam logic [8:0] OFS_FLOW_LOW = 9'h012;
  localparam logic [8:0] OFS_FLOW_HIGH = 9'h013;
  localparam logic [8:0] OFS_PRESCALE = 9'h014;
  localparam logic [8:0] OFS_RX_COUNT = 9'h015;
  localparam logic [8:0] OFS_TX_COUNT = 9'h016;
  localparam logic [8:0] OFS_GLOBAL_STAT = 9'h017;
  localparam logic [8:0] OFS_DATA_WIN = 9'h100;
  localparam logic [8:0] OFS_STAT_WIN = 9'h180;
  localparam int NUM_REGS = 24;
  // reset values
  localparam logic [7:0] HOLD_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] INT_STAT_IDLE = 8'hc1;
  // field positions
  localparam int SF_COUNT_SEL = 6;
  localparam int SF_TXCOUNT_SEL = 7;
  localparam int FC_FIFO_EN = 0;
  localparam int FC_RX_FLUSH = 1;
  localparam int FC_TX_FLUSH = 2;
  localparam int LS_DATA_READY = 0;
  localparam int LS_OVERRUN = 1;
  localparam int LS_TX_ROOM = 5;
  localparam int LS_TX_IDLE = 6;
  localparam int LS_RX_ERROR = 7;

  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
  } uam_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] status;
  } uam_rx_t;

  typedef struct packed {
    logic [15:0] divisor;
    logic [7:0] line_control;
    logic [7:0] baud_prescale;
    logic [7:0] sample_clock;
    logic [7:0] tx_holding;
    logic fifo_enable;
  } uam_cfg_t;
endpackage

// >>> design/uam_buf2.sv
// two-entry valid/ready buffer on the transmit data path
`timescale 1ns/1ps
`default_nettype none
module uam_buf2 #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// >>> design/uam_regs.sv
// memory-mapped register decode with per-channel receive and transmit queues
//
// Operation
// - every channel owns a 512-byte register block in memory mode
// - channel block base is base address register plus channel offset
// - channel 0 sits at offset 0000h, channel 1 at 0200h
// - byte offset within the block selects the register
// - offset 00h reads receive holding, writes go to transmit holding
// - offset 02h reads interrupt status, writes the fifo control register
// - decode 01h, 04h, 05h read-only, 06h read-only and 07h
// - divisor low and high at 08h and 09h, write-only
// - enhanced function at 0Ah, four flow characters at 0Bh to 0Eh
// - control 0Fh, triggers 10h/11h, thresholds 12h/13h, prescaler 14h
// - read-only count at 15h, count or sample clock 16h, global status 17h
// - fifo data window spans offsets 100h to 17Fh
// - per-entry line status window spans offsets 180h to 1FFh
// - reading receive holding returns and removes the oldest entry
// - writing transmit holding appends the byte to the transmit queue
// - a byte written while the transmit queue is full is dropped
// - line status reports receive empty and transmit full state of the queues, and transmit empty once queue and buffer both drain
// - 15h reads error counter when special bit 6 set, else rx count
// - 16h reads tx count when special bit 7 set, else sample clock
`timescale 1ns/1ps
`default_nettype none
module uam_regs
  import uam_pkg::*;
#(
  parameter int NCH = CHANNELS,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // memory access from the host
  input wire logic [31:0] mem_base,
  input wire logic mem_req_valid,
  input wire uam_req_t mem_req,
  output logic mem_rvalid,
  output logic [7:0] mem_rdata,
  // receive stream from the serial side
  input wire logic [NCH-1:0] rx_valid,
  output logic [NCH-1:0] rx_ready,
  input wire uam_rx_t [NCH-1:0] rx_word,
  // transmit stream to the serial side
  output logic [NCH-1:0] tx_valid,
  input wire logic [NCH-1:0] tx_ready,
  output logic [NCH-1:0][7:0] tx_data,
  // line side state and configuration
  input wire logic [NCH-1:0][7:0] modem_status,
  output uam_cfg_t [NCH-1:0] cfg
);
  localparam int AW = $clog2(DEPTH);

  // the window holds at most 128 entries and counts must fit eight bits
  if (DEPTH < 2 || DEPTH > 128 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two from 2 to 128");
  end
  if (NCH < 1 || NCH > 2) begin : g_bad_nch
    $error("NCH must be 1 or 2");
  end
  // the offset decode is built for 9-bit block offsets and a 5-bit register index
  if (BLOCK_BYTES != 512) begin : g_bad_block
    $error("BLOCK_BYTES must be 512 for the 9-bit offset decode");
  end
  if (NUM_REGS > 32) begin : g_bad_regs
    $error("NUM_REGS must fit the 5-bit register index");
  end

  logic [NCH-1:0] sel;
  logic [NCH-1:0][7:0] rd_byte;
  logic [NCH-1:0] data_ready;
  logic [7:0] global_stat;
  logic [7:0] rdata_d;

  assign global_stat = {{(8 - NCH){1'b0}}, data_ready};

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [31:0] rel;
    logic [8:0] ofs;
    logic wr;
    logic rd;
    logic [7:0] regs_q [NUM_REGS];
    uam_rx_t rx_mem_q [DEPTH];
    logic [7:0] tx_mem_q [DEPTH];
    logic [AW-1:0] rx_wp_q;
    logic [AW-1:0] rx_rp_q;
    logic [AW:0] rx_cnt_q;
    logic [AW-1:0] tx_wp_q;
    logic [AW-1:0] tx_rp_q;
    logic [AW:0] tx_cnt_q;
    logic [AW:0] err_cnt_q;
    logic [7:0] rx_holding_q;
    logic [7:0] tx_holding_q;
    logic overrun_q;
    logic fifo_en_q;
    logic push_rx;
    logic pop_rx;
    logic flush_rx;
    logic push_tx;
    logic pop_tx;
    logic flush_tx;
    logic buf_ready;
    logic buf_idle;
    logic win_wr;
    logic stat_wr;
    logic reg_wr;
    logic [AW-1:0] win_idx;
    uam_rx_t rx_head;
    logic [7:0] line_stat;
    logic [AW-1:0] live_ofs;
    logic patch_live;
    logic patch_up;
    logic patch_dn;

    assign rel = mem_req.addr - (mem_base + CH_STRIDE * 32'(c));
    assign sel[c] = mem_req_valid && (rel < 32'(BLOCK_BYTES));
    assign ofs = rel[8:0];
    assign wr = sel[c] && mem_req.we;
    assign rd = sel[c] && !mem_req.we;
    assign win_idx = ofs[AW-1:0];
    assign rx_head = rx_mem_q[rx_rp_q];

    // queue controls
    // hold off the stream during a flush so that no offered word is silently lost
    assign rx_ready[c] = (rx_cnt_q != (AW + 1)'(DEPTH)) && !flush_rx;
    assign push_rx = rx_valid[c] && rx_ready[c];
    assign pop_rx = rd && (ofs == OFS_HOLD) && (rx_cnt_q != '0);
    assign flush_rx = wr && (ofs == OFS_INT_FIFO) && mem_req.wdata[FC_RX_FLUSH];
    assign push_tx = wr && (ofs == OFS_HOLD) && (tx_cnt_q != (AW + 1)'(DEPTH));
    assign flush_tx = wr && (ofs == OFS_INT_FIFO) && mem_req.wdata[FC_TX_FLUSH];
    assign pop_tx = (tx_cnt_q != '0) && buf_ready && !flush_tx;
    assign win_wr = wr && (ofs >= OFS_DATA_WIN) && (ofs < OFS_STAT_WIN);
    assign stat_wr = wr && (ofs >= OFS_STAT_WIN);
    // read-only offsets and the holding and fifo control offsets keep no host-written copy here
    assign reg_wr = wr && (ofs < 9'(NUM_REGS)) && (ofs != OFS_HOLD) && (ofs != OFS_INT_FIFO)
                    && (ofs != OFS_LINE_STAT) && (ofs != OFS_MODEM_STAT)
                    && (ofs != OFS_RX_COUNT) && (ofs != OFS_GLOBAL_STAT);
    // a status patch on a queued entry keeps the error count in step with the queue
    assign live_ofs = win_idx - rx_rp_q;
    assign patch_live = stat_wr && ({1'b0, live_ofs} < rx_cnt_q);
    assign patch_up = patch_live && (rx_mem_q[win_idx].status == 8'h00)
                      && (mem_req.wdata != 8'h00);
    assign patch_dn = patch_live && (rx_mem_q[win_idx].status != 8'h00)
                      && (mem_req.wdata == 8'h00);

    // receive queue storage; the status window lets the host patch entry status
    always_ff @(posedge mclk) begin
      if (push_rx) begin
        rx_mem_q[rx_wp_q] <= rx_word[c];
      end
      if (stat_wr && !(push_rx && rx_wp_q == win_idx)) begin
        rx_mem_q[win_idx].status <= mem_req.wdata;
      end
    end

    always_ff @(posedge mclk) begin
      if (srst || flush_rx) begin
        rx_wp_q <= '0;
        rx_rp_q <= '0;
        rx_cnt_q <= '0;
      end else begin
        if (push_rx) begin
          rx_wp_q <= rx_wp_q + 1'b1;
        end
        if (pop_rx) begin
          rx_rp_q <= rx_rp_q + 1'b1;
        end
        rx_cnt_q <= rx_cnt_q + (AW + 1)'(push_rx) - (AW + 1)'(pop_rx);
      end
    end

    // entries carrying a nonzero status are counted for the error counter view
    always_ff @(posedge mclk) begin
      if (srst || flush_rx) begin
        err_cnt_q <= '0;
      end else begin
        err_cnt_q <= err_cnt_q + (AW + 1)'(push_rx && rx_word[c].status != 8'h00)
                     + (AW + 1)'(patch_up) - (AW + 1)'(patch_dn)
                     - (AW + 1)'(pop_rx && rx_head.status != 8'h00);
      end
    end

    always_ff @(posedge mclk) begin
      if (srst) begin
        rx_holding_q <= HOLD_RST;
        tx_holding_q <= HOLD_RST;
      end else begin
        if (pop_rx) begin
          rx_holding_q <= rx_head.data;
        end
        if (wr && ofs == OFS_HOLD) begin
          tx_holding_q <= mem_req.wdata;
        end
      end
    end

    // a word refused for lack of room sets overrun; a new one beats the read clear
    always_ff @(posedge mclk) begin
      if (srst || flush_rx) begin
        overrun_q <= 1'b0;
      end else if (rx_valid[c] && !rx_ready[c]) begin
        overrun_q <= 1'b1;
      end else if (rd && ofs == OFS_LINE_STAT) begin
        overrun_q <= 1'b0;
      end
    end

    // transmit queue storage; the data window writes entries in place
    always_ff @(posedge mclk) begin
      if (push_tx) begin
        tx_mem_q[tx_wp_q] <= mem_req.wdata;
      end
      if (win_wr) begin
        tx_mem_q[win_idx] <= mem_req.wdata;
      end
    end

    always_ff @(posedge mclk) begin
      if (srst || flush_tx) begin
        tx_wp_q <= '0;
        tx_rp_q <= '0;
        tx_cnt_q <= '0;
      end else begin
        if (push_tx) begin
          tx_wp_q <= tx_wp_q + 1'b1;
        end
        if (pop_tx) begin
          tx_rp_q <= tx_rp_q + 1'b1;
        end
        tx_cnt_q <= tx_cnt_q + (AW + 1)'(push_tx) - (AW + 1)'(pop_tx);
      end
    end

    // the buffer lets the serializer stall without costing a queued word
    uam_buf2 #(
      .WIDTH(8)
    ) u_txbuf (
      .mclk(mclk),
      .srst(srst),
      .in_valid(pop_tx),
      .in_ready(buf_ready),
      .in_data(tx_mem_q[tx_rp_q]),
      .out_valid(tx_valid[c]),
      .out_ready(tx_ready[c]),
      .out_data(tx_data[c])
    );
    assign buf_idle = !tx_valid[c];

    always_ff @(posedge mclk) begin
      if (srst) begin
        fifo_en_q <= 1'b0;
      end else if (wr && ofs == OFS_INT_FIFO) begin
        fifo_en_q <= mem_req.wdata[FC_FIFO_EN];
      end
    end

    always_ff @(posedge mclk) begin
      if (srst) begin
        for (int i = 0; i < NUM_REGS; i++) begin
          regs_q[i] <= REG_RST;
        end
      end else if (reg_wr) begin
        regs_q[ofs[4:0]] <= mem_req.wdata;
      end
    end

    always_comb begin
      line_stat = 8'h00;
      line_stat[LS_DATA_READY] = (rx_cnt_q != '0);
      line_stat[LS_OVERRUN] = overrun_q;
      line_stat[LS_TX_ROOM] = (tx_cnt_q != (AW + 1)'(DEPTH));
      // idle only once the buffer has drained too, so software can wait for the line
      line_stat[LS_TX_IDLE] = (tx_cnt_q == '0) && buf_idle;
      line_stat[LS_RX_ERROR] = (err_cnt_q != '0);
    end
    assign data_ready[c] = line_stat[LS_DATA_READY];

    // read view of the channel block
    always_comb begin
      rd_byte[c] = 8'h00;
      if (ofs >= OFS_STAT_WIN) begin
        rd_byte[c] = rx_mem_q[win_idx].status;
      end else if (ofs >= OFS_DATA_WIN) begin
        rd_byte[c] = rx_mem_q[win_idx].data;
      end else if (ofs < 9'(NUM_REGS)) begin
        case (ofs)
          // empty queue returns the last byte taken: not valid data
          OFS_HOLD: rd_byte[c] = (rx_cnt_q != '0) ? rx_head.data : rx_holding_q;
          OFS_INT_FIFO: rd_byte[c] = INT_STAT_IDLE;
          OFS_LINE_STAT: rd_byte[c] = line_stat;
          OFS_MODEM_STAT: rd_byte[c] = modem_status[c];
          OFS_DIV_LOW, OFS_DIV_HIGH: rd_byte[c] = 8'h00;
          OFS_RX_COUNT: begin
            if (regs_q[OFS_SPECIAL[4:0]][SF_COUNT_SEL]) begin
              rd_byte[c] = 8'(err_cnt_q);
            end else begin
              rd_byte[c] = 8'(rx_cnt_q);
            end
          end
          OFS_TX_COUNT: begin
            if (regs_q[OFS_SPECIAL[4:0]][SF_TXCOUNT_SEL]) begin
              rd_byte[c] = 8'(tx_cnt_q);
            end else begin
              rd_byte[c] = regs_q[OFS_TX_COUNT[4:0]];
            end
          end
          OFS_GLOBAL_STAT: rd_byte[c] = global_stat;
          default: rd_byte[c] = regs_q[ofs[4:0]];
        endcase
      end
    end

    assign cfg[c].divisor = {regs_q[OFS_DIV_HIGH[4:0]], regs_q[OFS_DIV_LOW[4:0]]};
    assign cfg[c].line_control = regs_q[OFS_LINE_CTRL[4:0]];
    assign cfg[c].baud_prescale = regs_q[OFS_PRESCALE[4:0]];
    assign cfg[c].sample_clock = regs_q[OFS_TX_COUNT[4:0]];
    assign cfg[c].tx_holding = tx_holding_q;
    assign cfg[c].fifo_enable = fifo_en_q;
  end

  always_comb begin
    rdata_d = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      if (sel[i]) begin
        rdata_d = rd_byte[i];
      end
    end
  end

  // one-cycle read answer for accesses that hit a channel block
  always_ff @(posedge mclk) begin
    if (srst) begin
      mem_rvalid <= 1'b0;
      mem_rdata <= 8'h00;
    end else begin
      mem_rvalid <= mem_req_valid && !mem_req.we && (sel != '0);
      // read data stands until the next read that hits a channel block so a slow host can still pick it up
      if (mem_req_valid && !mem_req.we && (sel != '0)) begin
        mem_rdata <= rdata_d;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/uam_regs_assertions.sv
// concurrent checks on the register decode ports
`timescale 1ns/1ps
`default_nettype none
module uam_regs_assertions
  import uam_pkg::*;
#(
  parameter int NCH = CHANNELS,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // host access
  input wire logic [31:0] mem_base,
  input wire logic mem_req_valid,
  input wire uam_req_t mem_req,
  input wire logic mem_rvalid,
  input wire logic [7:0] mem_rdata,
  // streams
  input wire logic [NCH-1:0] rx_valid,
  input wire logic [NCH-1:0] rx_ready,
  input wire uam_rx_t [NCH-1:0] rx_word,
  input wire logic [NCH-1:0] tx_valid,
  input wire logic [NCH-1:0] tx_ready,
  input wire logic [NCH-1:0][7:0] tx_data,
  // line side
  input wire logic [NCH-1:0][7:0] modem_status,
  input wire uam_cfg_t [NCH-1:0] cfg
);
  logic [31:0] ofs;
  logic rd;
  logic wr;
  logic hit;
  assign ofs = mem_req.addr - mem_base;
  assign rd = mem_req_valid && !mem_req.we;
  assign wr = mem_req_valid && mem_req.we;
  assign hit = ofs < 32'(NCH * BLOCK_BYTES);

  a_read_answer: assert property (@(posedge mclk) disable iff (srst) rd && hit |=> mem_rvalid)
    else $error("read inside a block got no answer");
  a_outside_silent: assert property (@(posedge mclk) disable iff (srst)
    !(rd && hit) |=> !mem_rvalid)
    else $error("answer without a read inside a block");
  a_isr_idle: assert property (@(posedge mclk) disable iff (srst)
    rd && ofs == 32'h2 |=> mem_rdata == INT_STAT_IDLE)
    else $error("interrupt status read wrong");
  a_modem_read: assert property (@(posedge mclk) disable iff (srst)
    rd && ofs == 32'h6 |=> mem_rdata == $past(modem_status[0]))
    else $error("modem status read wrong");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (srst)
    rd && ofs inside {[32'h18:32'hff]} |=> mem_rdata == 8'h00)
    else $error("unassigned offset read nonzero");
  a_divisor_wo: assert property (@(posedge mclk) disable iff (srst)
    rd && ofs[31:1] == 31'h4 |=> mem_rdata == 8'h00)
    else $error("write-only divisor readable");
  a_ch1_divisor: assert property (@(posedge mclk) disable iff (srst)
    wr && ofs == 32'h208 |=> cfg[1].divisor[7:0] == $past(mem_req.wdata))
    else $error("second block divisor not written");
  a_tx_holding: assert property (@(posedge mclk) disable iff (srst)
    wr && ofs == 32'h0 |=> cfg[0].tx_holding == $past(mem_req.wdata))
    else $error("transmit holding not written");
  a_tx_hold: assert property (@(posedge mclk) disable iff (srst)
    tx_valid[0] && !tx_ready[0] |=> tx_valid[0] && $stable(tx_data[0]))
    else $error("stalled transmit word changed");
  a_reset_clear: assert property (@(posedge mclk)
    srst |=> !mem_rvalid && mem_rdata == 8'h00 && cfg[0].tx_holding == HOLD_RST)
    else $error("reset did not clear outputs");
endmodule

bind uam_regs uam_regs_assertions #(.NCH(NCH), .DEPTH(DEPTH)) u_chk (
  .mclk(mclk), .srst(srst), .mem_base(mem_base), .mem_req_valid(mem_req_valid),
  .mem_req(mem_req), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .rx_word(rx_word), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_data(tx_data), .modem_status(modem_status), .cfg(cfg));
`default_nettype wire

// >>> dv/uam_line_model.sv
// serial-side model: feeds receive words to channel 0, drains transmit bytes
`timescale 1ns/1ps
`default_nettype none
module uam_line_model
  import uam_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // stall control
  input wire logic stall,
  // receive stream
  output logic [1:0] rx_valid,
  input wire logic [1:0] rx_ready,
  output uam_rx_t [1:0] rx_word,
  // transmit stream
  input wire logic [1:0] tx_valid,
  output logic [1:0] tx_ready,
  input wire logic [1:0][7:0] tx_data
);
  logic [7:0] got[$];
  int n_taken = 0;
  initial begin
    rx_valid = 2'h0;
    rx_word = '0;
  end
  assign tx_ready = {2{!stall}};
  always @(posedge mclk) begin
    if (!srst && tx_valid[0] && tx_ready[0]) begin
      got.push_back(tx_data[0]);
    end
  end
  // after the taking edge the word lines invert so a stale word never looks fresh
  // a word not taken within the tries is withdrawn; the bench checks n_taken
  task automatic send(input uam_rx_t w, input int tries = 64);
    @(posedge mclk);
    rx_valid[0] <= 1'b1;
    rx_word[0] <= w;
    for (int i = 0; i < tries; i++) begin
      @(posedge mclk);
      if (rx_ready[0]) begin
        n_taken++;
        break;
      end
    end
    rx_valid[0] <= 1'b0;
    rx_word[0] <= ~w;
  endtask
endmodule
`default_nettype wire

// >>> dv/test_uart_memory_mapped_register_decode.sv
// self-checking bench for the register decode
`timescale 1ns/1ps
`default_nettype none
module test_uart_memory_mapped_register_decode
  import uam_pkg::*;
;
  localparam int DEP = 4;
  localparam logic [31:0] BASE = 32'h0001_0000;
  localparam logic [7:0] RW_OFS [15] = '{8'h01, 8'h04, 8'h07, 8'h0a, 8'h0b, 8'h0c, 8'h0d,
    8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16};
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic stall = 1'b0;
  logic req_v = 1'b0;
  uam_req_t req = '0;
  logic mem_rvalid;
  logic [7:0] mem_rdata;
  logic [1:0] rx_valid;
  logic [1:0] rx_ready;
  logic [1:0] tx_valid;
  logic [1:0] tx_ready;
  uam_rx_t [1:0] rx_word;
  logic [1:0][7:0] tx_data;
  logic [1:0][7:0] modem = {8'h9b, 8'h36};
  uam_cfg_t [1:0] cfg;
  int n_errors = 0;
  int comparisons = 0;
  logic [7:0] d;

  always #25 mclk = ~mclk;

  uam_regs #(.NCH(2), .DEPTH(DEP)) u_dut (.mclk(mclk), .srst(srst), .mem_base(BASE),
    .mem_req_valid(req_v), .mem_req(req), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .modem_status(modem), .cfg(cfg));
  uam_line_model u_line (.mclk(mclk), .srst(srst), .stall(stall), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_word(rx_word), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one-cycle strobe; the design takes it at the next edge
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    @(posedge mclk);
    req_v <= 1'b1;
    req <= '{1'b1, BASE + a, v};
    @(posedge mclk);
    req_v <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [31:0] a, output logic [7:0] v, input logic hit = 1'b1);
    @(posedge mclk);
    req_v <= 1'b1;
    req <= '{1'b0, BASE + a, 8'h00};
    @(posedge mclk);
    req_v <= 1'b0;
    #1;
    chk(mem_rvalid, hit);
    v = mem_rdata;
  endtask

  task automatic rc(input logic [31:0] a, input logic [7:0] e);
    rd(a, d);
    chk(d, e);
  endtask

  initial begin
    #2_000_000;
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    rc(32'h000, HOLD_RST);
    chk(cfg[0].tx_holding, HOLD_RST);
    for (int c = 0; c < 2; c++) begin
      foreach (RW_OFS[i]) wr(CH_STRIDE * 32'(c) + 32'(RW_OFS[i]), 8'(RW_OFS[i] + 16 * c + 16));
      foreach (RW_OFS[i]) rc(CH_STRIDE * 32'(c) + 32'(RW_OFS[i]), 8'(RW_OFS[i] + 16 * c + 16));
    end
    chk(cfg[0].line_control, 8'h14);
    chk(cfg[1].baud_prescale, 8'h34);
    chk(cfg[0].sample_clock, 8'h26);
    chk(rx_ready[1], 1'b1);
    rc(32'h002, INT_STAT_IDLE);
    rc(32'h006, modem[0]);
    wr(32'h008, 8'h34);
    wr(32'h009, 8'h12);
    rc(32'h009, 8'h00);
    chk(cfg[0].divisor, 16'h1234);
    wr(32'h208, 8'h77);
    chk(cfg[1].divisor[7:0], 8'h77);
    wr(32'h040, 8'hff);
    rc(32'h040, 8'h00);
    rc(32'h018, 8'h00);
    rc(32'h0ff, 8'h00);
    rd(32'h400, d, 1'b0);
    rd(32'hffff_ffff, d, 1'b0);
    wr(32'h002, 8'h01);
    chk(cfg[0].fifo_enable, 1'b1);
    u_line.send({8'h5a, 8'h00});
    u_line.send({8'ha5, 8'h08});
    u_line.send({8'h3c, 8'h00});
    chk(16'(u_line.n_taken), 16'd3);
    rc(32'h015, 8'h03);
    rc(32'h005, 8'he1);
    rd(32'h017, d);
    chk(d & 8'h03, 8'h01);
    wr(32'h007, 8'h40);
    rc(32'h015, 8'h01);
    rc(32'h100, 8'h5a);
    rc(32'h181, 8'h08);
    wr(32'h181, 8'h00);
    rc(32'h015, 8'h00);
    rc(32'h000, 8'h5a);
    rc(32'h000, 8'ha5);
    rc(32'h000, 8'h3c);
    rc(32'h005, 8'h60);
    rd(32'h000, d);
    wr(32'h007, 8'h80);
    rc(32'h015, 8'h00);
    rc(32'h016, 8'h00);
    @(posedge mclk);
    stall <= 1'b1;
    for (int i = 0; i < 8; i++) wr(32'h000, 8'h80 + 8'(i));
    wr(32'h200, 8'h42);
    rd(32'h005, d);
    chk(d & 8'h20, 8'h00);
    chk(tx_valid[1], 1'b1);
    chk(tx_data[1], 8'h42);
    chk(cfg[0].tx_holding, 8'h87);
    @(posedge mclk);
    stall <= 1'b0;
    for (int i = 0; i < 100 && u_line.got.size() < 6; i++) @(posedge mclk);
    repeat (8) @(posedge mclk);
    chk(16'(u_line.got.size()), 16'd6);
    foreach (u_line.got[i]) chk(u_line.got[i], 8'h80 + 8'(i));
    rc(32'h005, 8'h60);
    for (int i = 0; i < 4; i++) u_line.send({8'h11 + 8'(i), 8'h00});
    u_line.send({8'hee, 8'h00}, 2);
    chk(16'(u_line.n_taken), 16'd7);
    rc(32'h005, 8'h63);
    chk(rx_ready[0], 1'b0);
    rc(32'h005, 8'h61);
    wr(32'h002, 8'h03);
    rc(32'h015, 8'h00);
    chk(rx_ready[0], 1'b1);
    @(posedge mclk);
    stall <= 1'b1;
    for (int i = 0; i < 3; i++) wr(32'h000, 8'h90 + 8'(i));
    rc(32'h016, 8'h01);
    wr(32'h002, 8'h05);
    rc(32'h016, 8'h00);
    chk(cfg[0].fifo_enable, 1'b1);
    @(posedge mclk);
    stall <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(16'(u_line.got.size()), 16'd8);
    print_verdict();
  end
endmodule
`default_nettype wire
